// [design/dma_fifo.sv]
// holding fifo between the read and write halves of a unit
`default_nettype none
module dma_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [design/dma_pkg.sv]
// constants shared by the dma request and cycle control block
// ----------------------------------------
// Overview of operation
// - every transfer unit costs its read count times j plus its write count times k clock cycles.
// - an 8-bit unit takes one read and one write; a 16-bit unit takes two of each unless even on a 16-bit bus.
// - any even or odd pairing of source and destination is accepted and split, never refused.
// - j/k is 1/1 or 2/2 internally, 1/2, 2/2, 3/3, 4/4 on the separate bus, 3/3 or 4/4 multiplexed.
// - a request is taken only while its request bit is set and its mode is 01 or 11.
// - with mode 00 a pending request is dropped and its request bit cleared.
// - reset puts every mode field at 00, and software must choose a mode before anything moves.
// - each channel picks its trigger from a peripheral, from software or from its external pin.
// - a peripheral trigger sets the request bit in the same cycle as its interrupt request.
// - the request bit clears when its transfer starts or when the channel is disabled; here a trigger in the start cycle keeps it set.
// - the external pin sets the request on a falling edge only or on both edges, as selected.
// - requests arriving in one sampling window set their request bits together.
// - among pending channels, channel zero wins, then one, then two, then three.
// - after each unit the bus goes back to the cpu, and the next unit waits for one cpu access.
// - an access to the register area or a waited area is one bus cycle longer.
// ----------------------------------------
`default_nettype none
package dma_pkg;
    localparam int NUM_CHAN = 4;
    localparam int CFG_W = 18;
    // register byte addresses
    localparam logic [7:0] ADDR_CFG_BASE = 8'h00;
    localparam logic [7:0] ADDR_COUNT_BASE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    // configuration fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_SRC_LSB = 2;
    localparam int CFG_WIDTH_BIT = 4;
    localparam int CFG_SRC_BUS_BIT = 5;
    localparam int CFG_DST_BUS_BIT = 6;
    localparam int CFG_SWREQ_BIT = 7;
    localparam int CFG_SRC_AREA_LSB = 8;
    localparam int CFG_DST_AREA_LSB = 12;
    localparam int CFG_SRC_ODD_BIT = 16;
    localparam int CFG_DST_ODD_BIT = 17;
    localparam logic [CFG_W-1:0] CFG_RESET = 18'h00000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // mode field
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_REPEAT = 2'h3;
    // trigger source field
    localparam logic [1:0] SRC_PERIPH = 2'h0;
    localparam logic [1:0] SRC_SOFT = 2'h1;
    localparam logic [1:0] SRC_EXT_FALL = 2'h2;
    localparam logic [1:0] SRC_EXT_BOTH = 2'h3;
    // memory area codes, whose coefficients dma_unit_cost gives
    localparam logic [3:0] AREA_INT_NOWAIT = 4'h0;
    localparam logic [3:0] AREA_INT_WAIT = 4'h1;
    localparam logic [3:0] AREA_SFR = 4'h2;
    localparam logic [3:0] AREA_SEP_W0 = 4'h3;
    localparam logic [3:0] AREA_SEP_W1 = 4'h4;
    localparam logic [3:0] AREA_SEP_W2 = 4'h5;
    localparam logic [3:0] AREA_SEP_W3 = 4'h6;
    localparam logic [3:0] AREA_MUX_W2 = 4'h7;
    localparam logic [3:0] AREA_MUX_W3 = 4'h8;
    localparam int FIFO_DEPTH = 8;
    localparam int DATA_W = 16;
endpackage
`default_nettype wire

// [design/dma_request_and_cycle_control.sv]
// four-channel dma request, arbitration and transfer cycle control
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`default_nettype none
module dma_request_and_cycle_control
    import dma_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic [dma_pkg::NUM_CHAN-1:0] periph_irq_set,
    input wire logic [dma_pkg::NUM_CHAN-1:0] external_request_pin,
    input wire logic cpu_access_done,
    output logic bus_own,
    output logic mem_rd,
    output logic mem_wr,
    output logic mem_part,
    output logic mem_byte,
    output logic [1:0] mem_chan,
    input wire logic [dma_pkg::DATA_W-1:0] mem_rdata,
    output logic [dma_pkg::DATA_W-1:0] mem_wdata,
    output logic unit_done
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } state_t;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // channel registers
    // ----------------------------------------
    logic [CFG_W-1:0] cfg [NUM_CHAN];
    logic [15:0] count [NUM_CHAN];
    logic [NUM_CHAN-1:0] req;
    logic [NUM_CHAN-1:0] sw_set;
    logic [NUM_CHAN-1:0] start;
    logic [NUM_CHAN-1:0] enabled;
    logic [NUM_CHAN-1:0] disabled;
    logic [NUM_CHAN-1:0] trig;
    logic [NUM_CHAN-1:0] cfg_hit;
    logic [NUM_CHAN-1:0] count_hit;

    function automatic logic [1:0] mode_of(input logic [CFG_W-1:0] c);
        return c[CFG_MODE_LSB +: 2];
    endfunction

    function automatic logic [1:0] src_of(input logic [CFG_W-1:0] c);
        return c[CFG_SRC_LSB +: 2];
    endfunction

    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            cfg_hit[i] = reg_write && (reg_addr == ADDR_CFG_BASE + 8'(4 * i));
            count_hit[i] = reg_write && (reg_addr == ADDR_COUNT_BASE + 8'(4 * i));
            sw_set[i] = cfg_hit[i] && reg_wdata[CFG_SWREQ_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                cfg[i] <= CFG_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (cfg_hit[i]) begin
                    cfg[i] <= reg_wdata[CFG_W-1:0];
                end
            end
        end
    end

    // software write beats the per-unit decrement
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                count[i] <= COUNT_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (count_hit[i]) begin
                    count[i] <= reg_wdata[15:0];
                end else if (start[i]) begin
                    count[i] <= count[i] - 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------
    // external pins
    // ----------------------------------------
    logic [NUM_CHAN-1:0] pin_meta;
    logic [NUM_CHAN-1:0] pin_sync;
    logic [NUM_CHAN-1:0] pin_last;
    logic [NUM_CHAN-1:0] pin_fall;
    logic [NUM_CHAN-1:0] pin_rise;

    // pins idle high, so no false edge at reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '1;
            pin_sync <= '1;
            pin_last <= '1;
        end else begin
            pin_meta <= external_request_pin;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    assign pin_fall = pin_last & ~pin_sync;
    assign pin_rise = ~pin_last & pin_sync;

    // ----------------------------------------
    // request bits
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            unique case (src_of(cfg[i]))
                SRC_PERIPH: trig[i] = periph_irq_set[i];
                SRC_SOFT: trig[i] = sw_set[i];
                SRC_EXT_FALL: trig[i] = pin_fall[i];
                SRC_EXT_BOTH: trig[i] = pin_fall[i] | pin_rise[i];
            endcase
            disabled[i] = (mode_of(cfg[i]) == MODE_OFF) || (count[i] == 16'h0000);
            enabled[i] = req[i] && !disabled[i] &&
                ((mode_of(cfg[i]) == MODE_SINGLE) || (mode_of(cfg[i]) == MODE_REPEAT));
        end
    end

    // one edge for all channels, so one window sets them together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req <= '0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (disabled[i]) begin
                    req[i] <= 1'b0;
                end else if (trig[i]) begin
                    req[i] <= 1'b1;
                end else if (start[i]) begin
                    req[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    state_t state;
    logic owed;
    logic grant_ok;
    logic [1:0] grant;
    logic [1:0] cur_chan;
    logic [CFG_W-1:0] cur_cfg;

    always_comb begin
        grant = 2'h0;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (enabled[i]) begin
                grant = 2'(i);
            end
        end
    end

    // fresh pick after each cpu access
    assign grant_ok = (state == ST_IDLE) && !owed && (enabled != '0);

    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            start[i] = grant_ok && (grant == 2'(i));
        end
    end

    // ----------------------------------------
    // unit cost
    // ----------------------------------------
    logic [1:0] n_rd;
    logic [1:0] n_wr;
    logic [2:0] j_coeff;
    logic [2:0] k_coeff;
    logic [7:0] expected;

    dma_unit_cost src_cost (
        .wide_unit(cur_cfg[CFG_WIDTH_BIT]),
        .bus16(cur_cfg[CFG_SRC_BUS_BIT]),
        .odd(cur_cfg[CFG_SRC_ODD_BIT]),
        .area(cur_cfg[CFG_SRC_AREA_LSB +: 4]),
        .is_write(1'b0),
        .accesses(n_rd),
        .coeff(j_coeff)
    );

    dma_unit_cost dst_cost (
        .wide_unit(cur_cfg[CFG_WIDTH_BIT]),
        .bus16(cur_cfg[CFG_DST_BUS_BIT]),
        .odd(cur_cfg[CFG_DST_ODD_BIT]),
        .area(cur_cfg[CFG_DST_AREA_LSB +: 4]),
        .is_write(1'b1),
        .accesses(n_wr),
        .coeff(k_coeff)
    );

    assign expected = 8'(n_rd * j_coeff) + 8'(n_wr * k_coeff);

    // ----------------------------------------
    // transfer engine
    // ----------------------------------------
    logic [2:0] tick;
    logic [7:0] hold;
    logic [7:0] cycles;
    logic [7:0] last_cycles;
    logic last_tick;
    logic last_part;
    logic [DATA_W-1:0] next_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_head;
    logic push;
    logic pop;

    function automatic logic [DATA_W-1:0] piece(input logic [DATA_W-1:0] w, input logic split,
                                                 input logic hi);
        if (!split) begin
            return w;
        end
        return hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    endfunction

    assign last_tick = tick == (state == ST_WRITE ? k_coeff : j_coeff) - 3'h1;
    assign last_part = mem_part == (state == ST_WRITE ? n_wr[1] : n_rd[1]);
    assign next_word = n_rd[1] ? {mem_rdata[7:0], hold} : mem_rdata;
    // a full fifo stalls the last read cycle
    assign push = (state == ST_READ) && last_tick && last_part;
    assign pop = (state == ST_WRITE) && last_tick && last_part;

    dma_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) hold_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(next_word),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_head)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            tick <= 3'h0;
            mem_part <= 1'b0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            bus_own <= 1'b0;
            cur_chan <= 2'h0;
            cur_cfg <= CFG_RESET;
            hold <= 8'h00;
            mem_wdata <= '0;
            unit_done <= 1'b0;
        end else begin
            unit_done <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (grant_ok) begin
                        state <= ST_READ;
                        bus_own <= 1'b1;
                        mem_rd <= 1'b1;
                        cur_chan <= grant;
                        cur_cfg <= cfg[grant];
                        tick <= 3'h0;
                        mem_part <= 1'b0;
                    end
                end
                ST_READ: begin
                    if (!last_tick) begin
                        tick <= tick + 3'h1;
                    end else if (!last_part) begin
                        hold <= mem_rdata[7:0];
                        mem_part <= 1'b1;
                        tick <= 3'h0;
                    end else if (fifo_in_ready) begin
                        state <= ST_WRITE;
                        mem_rd <= 1'b0;
                        mem_wr <= 1'b1;
                        mem_part <= 1'b0;
                        tick <= 3'h0;
                        mem_wdata <= piece(next_word, n_wr[1], 1'b0);
                    end
                end
                ST_WRITE: begin
                    if (!last_tick) begin
                        tick <= tick + 3'h1;
                    end else if (!last_part) begin
                        mem_part <= 1'b1;
                        tick <= 3'h0;
                        mem_wdata <= piece(fifo_head, 1'b1, 1'b1);
                    end else begin
                        state <= ST_IDLE;
                        mem_wr <= 1'b0;
                        bus_own <= 1'b0;
                        mem_part <= 1'b0;
                        unit_done <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // cpu must get one access before the next unit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            owed <= 1'b0;
        end else if (pop) begin
            owed <= 1'b1;
        end else if (cpu_access_done) begin
            owed <= 1'b0;
        end
    end

    // measured unit cost, shown in status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycles <= 8'h00;
            last_cycles <= 8'h00;
        end else if (state == ST_IDLE) begin
            cycles <= 8'h00;
        end else begin
            cycles <= cycles + 8'h01;
            if (pop) begin
                last_cycles <= cycles + 8'h01;
            end
        end
    end

    assign mem_byte = (state == ST_WRITE) ? n_wr[1] : n_rd[1];
    assign mem_chan = cur_chan;

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            reg_rdata <= 32'h00000000;
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (reg_addr == ADDR_CFG_BASE + 8'(4 * i)) begin
                    reg_rdata <= 32'(cfg[i] & ~(18'h1 << CFG_SWREQ_BIT));
                end
                if (reg_addr == ADDR_COUNT_BASE + 8'(4 * i)) begin
                    reg_rdata <= {16'h0000, count[i]};
                end
            end
            if (reg_addr == ADDR_STATUS) begin
                reg_rdata <= 32'({expected, last_cycles, owed, cur_chan, bus_own, req});
            end
        end
    end
endmodule
`default_nettype wire

// [design/dma_unit_cost.sv]
// access count and per-access coefficient of one side of a transfer unit
`default_nettype none
module dma_unit_cost
    import dma_pkg::*;
(
    input wire logic wide_unit,
    input wire logic bus16,
    input wire logic odd,
    input wire logic [3:0] area,
    input wire logic is_write,
    output logic [1:0] accesses,
    output logic [2:0] coeff
);
    // ----------------------------------------
    // coefficient table
    // ----------------------------------------
    function automatic logic [2:0] coeff_of(input logic [3:0] a, input logic wr);
        logic [2:0] c;
        c = 3'h1;
        unique case (a)
            AREA_INT_NOWAIT: c = 3'h1;
            AREA_INT_WAIT, AREA_SFR, AREA_SEP_W1: c = 3'h2;
            AREA_SEP_W0: c = wr ? 3'h2 : 3'h1;
            AREA_SEP_W2, AREA_MUX_W2: c = 3'h3;
            AREA_SEP_W3, AREA_MUX_W3: c = 3'h4;
            default: c = 3'h1;
        endcase
        return c;
    endfunction

    // misaligned or narrow-bus words split in two
    assign accesses = (wide_unit && (odd || !bus16)) ? 2'h2 : 2'h1;
    assign coeff = coeff_of(area, is_write);
endmodule
`default_nettype wire

// [tb/dma_checker_asserts.sv]
// port checker for the dma request and cycle control block
`default_nettype none
module dma_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic cpu_access_done,
    input wire logic bus_own,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_part,
    input wire logic mem_byte,
    input wire logic [1:0] mem_chan,
    input wire logic unit_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ------
    // helpers
    // ------
    logic owed;
    logic [3:0] rd_run;
    logic [3:0] wr_run;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            owed <= 1'b0;
        end else begin
            owed <= (owed | unit_done) & ~cpu_access_done;
        end
    end
    // saturating, so a stuck strobe trips
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_run <= 4'h0;
            wr_run <= 4'h0;
        end else begin
            rd_run <= mem_rd ? rd_run + {3'h0, rd_run != 4'hf} : 4'h0;
            wr_run <= mem_wr ? wr_run + {3'h0, wr_run != 4'hf} : 4'h0;
        end
    end
    // ------
    // properties
    // ------
    sequence rd_end;
        $fell(mem_rd);
    endsequence
    sequence unit_close;
        unit_done && !bus_own;
    endsequence
    rd_wr_apart_a: assert property (!(mem_rd && mem_wr))
        else $error("read and write overlap");
    wr_follows_rd_a: assert property (rd_end |-> mem_wr)
        else $error("no write after read");
    rd_before_wr_a: assert property ($rose(mem_wr) |-> $past(mem_rd))
        else $error("write without read");
    access_owned_a: assert property ((mem_rd || mem_wr) |-> bus_own)
        else $error("unowned access");
    unit_return_a: assert property ($fell(mem_wr) |-> unit_close)
        else $error("bus kept after unit");
    done_pulse_a: assert property (unit_done |=> !unit_done)
        else $error("unit done too long");
    cpu_turn_a: assert property ($rose(bus_own) |-> !(owed || unit_done))
        else $error("unit started before cpu access");
    rd_bound_a: assert property (rd_run <= 4'h8)
        else $error("read phase too long");
    wr_bound_a: assert property (wr_run <= 4'h8)
        else $error("write phase too long");
    part_first_a: assert property (($rose(mem_rd) || $rose(mem_wr)) |-> !mem_part)
        else $error("side begins with second part");
    part_split_a: assert property ((mem_part && (mem_rd || mem_wr)) |-> mem_byte)
        else $error("second part on unsplit side");
    chan_hold_a: assert property ((bus_own && $past(bus_own)) |-> $stable(mem_chan))
        else $error("channel changed within unit");
    rdata_hold_a: assert property (!$past(reg_read) |-> $stable(reg_rdata))
        else $error("read data moved unread");
endmodule
bind dma_request_and_cycle_control dma_checker chk (.clk(clk), .arst_n(arst_n),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .cpu_access_done(cpu_access_done),
    .bus_own(bus_own), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_part(mem_part),
    .mem_byte(mem_byte), .mem_chan(mem_chan), .unit_done(unit_done));
`default_nettype wire

// [tb/dma_far_side.sv]
// cpu and memory standing on the far side of the dma bus
`default_nettype none
module dma_far_side (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic bus_own,
    output logic cpu_access_done,
    output logic [dma_pkg::DATA_W-1:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 2'h0;
            cpu_access_done <= 1'b0;
            mem_rdata <= 16'h5a3c;
        end else begin
            phase <= phase + 2'h1;
            // cpu access on every fourth cycle, when the bus is free
            cpu_access_done <= !bus_own && phase == 2'h3;
            // data never holds, so late samples show
            mem_rdata <= mem_rdata + 16'h3b1d;
        end
    end
endmodule
`default_nettype wire

// [tb/dma_request_and_cycle_control_bench.sv]
// self-checking bench for the dma request and cycle control block
`default_nettype none
module dma_request_and_cycle_control_bench
    import dma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // signals
    // ------
    logic clk = 0, arst_n = 0, reg_write = 0, reg_read = 0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [3:0] periph = 4'h0, pins = 4'hf;
    logic cpu_done, bus_own, mem_rd, mem_wr, unit_done, rd_pend = 0;
    logic [1:0] mem_chan, ch = 2'h0;
    logic [15:0] mem_rdata, mem_wdata;
    logic [7:0] nr = 8'h0, nw = 8'h0, wd;
    logic [3:0] a, b;
    logic [4:0] f;
    logic [31:0] exp_r[$];
    logic [17:0] exp_u[$];
    int fail_count = 0, n_checks = 0, cycles = 0;
    localparam int JV [9] = '{1, 2, 2, 1, 2, 3, 4, 3, 4};
    localparam int KV [9] = '{1, 2, 2, 2, 2, 3, 4, 3, 4};
    localparam logic [1:0] ORDER [5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3};
    always #4 clk = ~clk;
    dma_request_and_cycle_control DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .periph_irq_set(periph), .external_request_pin(pins), .cpu_access_done(cpu_done),
        .bus_own(bus_own), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_part(), .mem_byte(),
        .mem_chan(mem_chan), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .unit_done(unit_done));
    dma_far_side far (.clk(clk), .arst_n(arst_n), .bus_own(bus_own), .cpu_access_done(cpu_done),
        .mem_rdata(mem_rdata));
    // ------
    // tasks
    // ------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic int acc(logic wide, logic bus16, logic odd);
        return (wide && (!bus16 || odd)) ? 2 : 1;
    endfunction
    task wr(input logic [7:0] ad, input logic [31:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] e);
        exp_r.push_back(e);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
    endtask
    task pulse(input logic [3:0] v);
        periph <= v;
        @(posedge clk);
        periph <= 4'h0;
        @(posedge clk);
    endtask
    // bounded wait for noted units
    task drain;
        for (int i = 0; i < 400 && exp_u.size() != 0; i++) @(posedge clk);
        check("units left", 32'(exp_u.size()), 32'h0);
        repeat (4) @(posedge clk);
    endtask
    // ------
    // monitor
    // ------
    always @(posedge clk) begin
        if (rd_pend) check("read data", reg_rdata, exp_r.pop_front());
        rd_pend = reg_read;
        if (mem_rd) begin
            nr++;
            ch = mem_chan;
            wd = mem_rdata[7:0];
        end
        if (mem_wr && nw + nr == 1) check("write data", 32'(mem_wdata[7:0]), 32'(wd));
        if (mem_wr) nw++;
        if (unit_done) begin
            if (exp_u.size() == 0) check("spare unit", 32'h1, 32'h0);
            else check("unit", {14'h0, ch, nr, nw}, {14'h0, exp_u.pop_front()});
            nr = 8'h0;
            nw = 8'h0;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // ------
    // sequence
    // ------
    initial begin
        void'($urandom(25979));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_CFG_BASE + 8'(4 * i), 32'h0);
            rd(ADDR_COUNT_BASE + 8'(4 * i), 32'h0);
        end
        rd(8'h30, 32'h0);
        wr(ADDR_CFG_BASE, 32'h5);
        // software units, random in width, bus, area and odd fields
        for (int n = 0; n < 14; n++) begin
            a = 4'($urandom % 9);
            b = 4'($urandom % 9);
            f = 5'($urandom);
            wr(ADDR_COUNT_BASE, 32'h1);
            exp_u.push_back({2'h0, 8'(acc(f[0], f[1], f[3]) * JV[a]), 8'(acc(f[0], f[2], f[4]) * KV[b])});
            wr(ADDR_CFG_BASE, {14'h0, f[4], f[3], b, a, 1'b1, f[2], f[1], f[0], SRC_SOFT, MODE_SINGLE});
            drain();
        end
        // four triggers at once, channel zero again mid-run
        wr(ADDR_COUNT_BASE, 32'h2);
        for (int i = 1; i < 4; i++) wr(ADDR_COUNT_BASE + 8'(4 * i), 32'h1);
        for (int i = 0; i < 4; i++) wr(ADDR_CFG_BASE + 8'(4 * i), {30'h0, MODE_REPEAT});
        foreach (ORDER[k]) exp_u.push_back({ORDER[k], 16'h0101});
        pulse(4'hf);
        for (int i = 0; i < 200 && !(bus_own && mem_chan == 2'h1); i++) @(posedge clk);
        pulse(4'h1);
        drain();
        // disabled channels
        wr(ADDR_COUNT_BASE + 8'hc, 32'h1);
        wr(ADDR_CFG_BASE + 8'hc, 32'h0);
        pulse(4'ha);
        repeat (12) @(posedge clk);
        wr(ADDR_CFG_BASE + 8'hc, {30'h0, MODE_SINGLE});
        repeat (12) @(posedge clk);
        exp_u.push_back({2'h3, 16'h0101});
        pulse(4'h8);
        drain();
        // falling edge, then both
        wr(ADDR_COUNT_BASE + 8'h8, 32'h3);
        wr(ADDR_CFG_BASE + 8'h8, {28'h0, SRC_EXT_FALL, MODE_SINGLE});
        exp_u.push_back({2'h2, 16'h0101});
        pins[2] <= 1'b0;
        drain();
        pins[2] <= 1'b1;
        repeat (12) @(posedge clk);
        wr(ADDR_CFG_BASE + 8'h8, {28'h0, SRC_EXT_BOTH, MODE_SINGLE});
        repeat (2) begin
            exp_u.push_back({2'h2, 16'h0101});
            pins[2] <= ~pins[2];
            drain();
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
